// file: common/gain_trim_regs.svh
// Register offsets, field positions and reset values of the gain trim and filter group.
// Assumes byte-wide registers on a 12-bit register address.
`ifndef GAIN_TRIM_REGS_SVH
`define GAIN_TRIM_REGS_SVH
// ======================================
// Offsets
`define OFS_FG_A0_DUAL 12'h350
`define OFS_FG_A1_DUAL 12'h351
`define OFS_FG_B0_DUAL 12'h352
`define OFS_FG_B1_DUAL 12'h353
`define OFS_FG_A0_SINGLE 12'h354
`define OFS_FG_A1_SINGLE 12'h355
`define OFS_FG_B0_SINGLE 12'h356
`define OFS_FG_B1_SINGLE 12'h357
`define OFS_EQ_FILTER_CONFIG 12'h400
// ======================================
// Fields
`define FG_TRIM_MSB 4
`define FG_TRIM_LSB 0
`define CFG_SHARE_BIT 6
`define CFG_MERGE_BIT 5
`define CFG_SCW_MSB 4
`define CFG_SCW_LSB 2
`define CFG_MODE_MSB 1
`define CFG_MODE_LSB 0
`define SCW_MAX 3'h6
`define SCW_LSB_EXP_BASE 6'sh10
// ======================================
// Reset values
`define FG_TRIM_RESET 5'h00
`define EQ_CONFIG_RESET 8'h00
`endif

// file: common/gain_trim_pkg.sv
// Types shared by the gain trim register group.
// Assumes the offset header is included where numbers are needed.
package gain_trim_pkg;
   typedef logic [4:0] trim_type;
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_RSV1 = 2'b01,
      MODE_ON = 2'b10,
      MODE_RSV3 = 2'b11
   } eq_mode_type;
   typedef enum logic [1:0] {
      COEF_OWN = 2'b00,
      COEF_SHARED = 2'b01,
      COEF_MERGED = 2'b10
   } coef_src_type;
endpackage

// file: common/trim_bus_if.sv
// Carrier between the register block and its trim storage.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface trim_bus_if;
   logic wrEn;
   logic [2:0] wrIdx;
   logic [4:0] wrData;
   logic [2:0] rdIdx;
   logic [4:0] rdData;
   modport master (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
   modport store (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface

// file: rtl/trim_store.sv
// Eight 5-bit fine gain trims with a registered read port.
// Assumes sys_clk and asynchronous active-high rst.
`timescale 1ns/1ps
module trim_store
   import gain_trim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   trim_bus_if.store tb,
   output trim_type trimAll [8]
);
`include "gain_trim_regs.svh"
   trim_type mem_r [8];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            mem_r[i] <= `FG_TRIM_RESET;
         end
         tb.rdData <= `FG_TRIM_RESET;
      end else begin
         if (tb.wrEn) begin
            mem_r[tb.wrIdx] <= tb.wrData;
         end
         tb.rdData <= mem_r[tb.rdIdx];
      end
   end
   assign trimAll = mem_r;
endmodule

// file: rtl/gain_trim_and_fir_config_regs.sv
// Fine gain trim and equalisation filter configuration registers.
// Assumes a single-cycle strobe register port on sys_clk.
// =====================================================================
// What this block does
// RQ1: Four dual-mode fine gain trims for core A/B bank 0/1, 5 bits, bits 7:5 reserved.
// RQ2: A second independent set of four 5-bit trims used in single channel mode.
// RQ3: Every trim reads zero after reset; fuse defaults are loaded elsewhere.
// RQ4: With the share bit set, channel B filter uses channel A coefficients; the code selects COEF_MERGED instead when the merge bit is also set.
// RQ5: With the share bit clear, channel B filter uses its own coefficients; the code selects COEF_MERGED instead when the merge bit is set.
// RQ6: With the merge bit set, both filters act as one filter on one stream.
// RQ7: Software sets the merge bit whenever single channel mode is selected.
// RQ8: Side weight field 4:2 sets the side coefficient LSB weight to 2^(field-16).
// RQ9: Software writes only 0 to 6 into the side weight field.
// RQ10: The filter configuration resets to zero, bit 7 reserved.
// RQ11: Mode code 0 disables the filter, code 2 enables it, 1 and 3 reserved.
// RQ12: Software changes filter setup only while the serial link is disabled.
// RQ13: The trim set applied follows the selected channel mode.
`timescale 1ns/1ps
module gain_trim_and_fir_config_regs
   import gain_trim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   input wire logic singleChannelMode,
   input wire logic serialLinkEnable,
   output logic [4:0] trimCoreABank0,
   output logic [4:0] trimCoreABank1,
   output logic [4:0] trimCoreBBank0,
   output logic [4:0] trimCoreBBank1,
   output logic eqFilterEnable,
   output logic [1:0] coefSrcB,
   output logic filtersMergeOneStream,
   output logic [5:0] sideLsbExpNeg,
   output logic setupWhileLinkOn
);
`include "gain_trim_regs.svh"
   // =====================================================================
   // Address decode
   function automatic logic isTrim(input logic [11:0] a);
      return (a >= `OFS_FG_A0_DUAL) && (a <= `OFS_FG_B1_SINGLE);
   endfunction
   trim_bus_if tb ();
   trim_type trimAll [8];
   logic [7:0] eqCfg_r;
   logic [7:0] eqCfg_nxt;
   logic rdTrim_r;
   logic rdCfg_r;
   logic [7:0] cfgRd_r;
   wire hitTrim = isTrim(regAddr);
   wire hitCfg = (regAddr == `OFS_EQ_FILTER_CONFIG);
   wire [2:0] trimIdx = regAddr[2:0];
   // =====================================================================
   // Trim storage
   assign tb.wrEn = regWrStb && hitTrim; // RQ1 RQ2
   assign tb.wrIdx = trimIdx;
   assign tb.wrData = regWrData[`FG_TRIM_MSB:`FG_TRIM_LSB];
   assign tb.rdIdx = trimIdx;
   trim_store uStore (
      .sys_clk(sys_clk),
      .rst(rst), // RQ3
      .tb(tb),
      .trimAll(trimAll)
   );
   // =====================================================================
   // Filter configuration
   assign eqCfg_nxt = (regWrStb && hitCfg) ? {1'b0, regWrData[6:0]} : eqCfg_r;
   wire share = eqCfg_r[`CFG_SHARE_BIT];
   wire merge = eqCfg_r[`CFG_MERGE_BIT];
   wire [2:0] scw = eqCfg_r[`CFG_SCW_MSB:`CFG_SCW_LSB];
   eq_mode_type mode;
   assign mode = eq_mode_type'(eqCfg_r[`CFG_MODE_MSB:`CFG_MODE_LSB]);
   // Reserved mode codes leave the filter off rather than guess
   wire enNxt = (mode == MODE_ON); // RQ11
   coef_src_type srcNxt;
   assign srcNxt = merge ? COEF_MERGED : (share ? COEF_SHARED : COEF_OWN); // RQ4 RQ5 RQ6
   // Exponent magnitude 16-scw; values 7 pass through unchecked
   wire [5:0] expNxt = 6'(6'h10 - {3'h0, scw}); // RQ8 RQ9
   wire cfgWr = regWrStb && hitCfg;
   // Trims chosen by channel mode; single mode also expects merge set
   wire [2:0] setBase = singleChannelMode ? 3'h4 : 3'h0; // RQ13 RQ7
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         eqCfg_r <= `EQ_CONFIG_RESET; // RQ10
         eqFilterEnable <= 1'b0;
         coefSrcB <= COEF_OWN;
         filtersMergeOneStream <= 1'b0;
         sideLsbExpNeg <= 6'h10;
         setupWhileLinkOn <= 1'b0;
      end else begin
         eqCfg_r <= eqCfg_nxt;
         eqFilterEnable <= enNxt;
         coefSrcB <= srcNxt;
         filtersMergeOneStream <= merge; // RQ6
         sideLsbExpNeg <= expNxt;
         // Sticky flag of a setup write with the link running
         setupWhileLinkOn <= setupWhileLinkOn | (cfgWr && serialLinkEnable); // RQ12
      end
   end
   // =====================================================================
   // Applied trims
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trimCoreABank0 <= `FG_TRIM_RESET;
         trimCoreABank1 <= `FG_TRIM_RESET;
         trimCoreBBank0 <= `FG_TRIM_RESET;
         trimCoreBBank1 <= `FG_TRIM_RESET;
      end else begin
         trimCoreABank0 <= trimAll[setBase]; // RQ13
         trimCoreABank1 <= trimAll[3'(setBase + 3'h1)];
         trimCoreBBank0 <= trimAll[3'(setBase + 3'h2)];
         trimCoreBBank1 <= trimAll[3'(setBase + 3'h3)];
      end
   end
   // =====================================================================
   // Read path: store data is registered, so the select is too
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdTrim_r <= 1'b0;
         rdCfg_r <= 1'b0;
         cfgRd_r <= 8'h00;
      end else begin
         rdTrim_r <= regRdStb && hitTrim;
         rdCfg_r <= regRdStb && hitCfg;
         cfgRd_r <= eqCfg_r;
      end
   end
   // Output mux after flops; unmapped reads return zero
   always_comb begin
      regRdData = 8'h00;
      if (rdTrim_r) begin
         regRdData = {3'h0, tb.rdData}; // RQ1
      end else if (rdCfg_r) begin
         regRdData = cfgRd_r;
      end
   end
endmodule

// file: test/gain_trim_regs_assertions.sv
// Port checks of the gain trim and filter register group.
// Assumes one clock sys_clk and async reset rst.
`timescale 1ns/1ps
module gain_trim_regs_assertions (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [7:0] regRdData,
   input wire logic singleChannelMode,
   input wire logic serialLinkEnable,
   input wire logic [4:0] trimCoreABank0,
   input wire logic eqFilterEnable,
   input wire logic [1:0] coefSrcB,
   input wire logic filtersMergeOneStream,
   input wire logic [5:0] sideLsbExpNeg,
   input wire logic setupWhileLinkOn
);
   // ======
   // Checks
   wire cfgWr = regWrStb && regAddr == 12'h400;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Derived outputs lag the register by one edge, so a second write voids the check
   sequence s_quiet; !cfgWr; endsequence
   property p_trimRsv;
      $past(regRdStb) && $past(regAddr) inside {[12'h350:12'h357]} |-> !regRdData[7:5];
   endproperty
   a_trimRsv: assert property (p_trimRsv) else $error("trim high bits");
   property p_cfgRsv; $past(regRdStb) && $past(regAddr) == 12'h400 |-> !regRdData[7]; endproperty
   a_cfgRsv: assert property (p_cfgRsv) else $error("config bit 7");
   property p_mode; logic [7:0] d;
      (cfgWr, d = regWrData) ##1 s_quiet |=> eqFilterEnable == (d[1:0] == 2'b10); endproperty
   a_mode: assert property (p_mode) else $error("filter enable");
   property p_share; (cfgWr && regWrData[6:5] == 2'b10) ##1 s_quiet |=> coefSrcB == 2'b01;
   endproperty
   a_share: assert property (p_share) else $error("share source");
   property p_merge; logic [7:0] d;
      (cfgWr, d = regWrData) ##1 s_quiet |=> filtersMergeOneStream == d[5]
         && (!d[5] || coefSrcB == 2'b10); endproperty
   a_merge: assert property (p_merge) else $error("merge");
   property p_scw; logic [7:0] d;
      (cfgWr, d = regWrData) ##1 s_quiet |=> sideLsbExpNeg == 6'h10 - {3'h0, d[4:2]}; endproperty
   a_scw: assert property (p_scw) else $error("side weight");
   property p_trimSel; logic [7:0] d;
      (regWrStb && regAddr == 12'h350 && !singleChannelMode, d = regWrData)
         ##1 (!regWrStb && !singleChannelMode) |=> trimCoreABank0 == d[4:0]; endproperty
   a_trimSel: assert property (p_trimSel) else $error("dual trim");
   property p_flag; (cfgWr && serialLinkEnable) |-> ##2 setupWhileLinkOn [*3]; endproperty
   a_flag: assert property (p_flag) else $error("link flag");
endmodule
bind gain_trim_and_fir_config_regs gain_trim_regs_assertions chk (.*);

// file: test/gain_trim_and_fir_config_regs_tb.sv
// Bench: strobe reads and writes with expected values.
// Assumes read data in the cycle after the read strobe.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module gain_trim_and_fir_config_regs_tb;
   logic sys_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0, singleChannelMode = 0;
   logic serialLinkEnable = 0, eqFilterEnable, filtersMergeOneStream, setupWhileLinkOn;
   logic [11:0] regAddr = 0;
   logic [7:0] regWrData = 0, regRdData;
   logic [4:0] trimCoreABank0, trimCoreABank1, trimCoreBBank0, trimCoreBBank1;
   logic [1:0] coefSrcB;
   logic [5:0] sideLsbExpNeg;
   // Side weight stays within 0 to 6 in every setting except 8'h1c, which writes 7
   logic [7:0] cfgs [9] = '{8'h02, 8'h40, 8'h00, 8'h20, 8'h60, 8'h18, 8'h1c, 8'h81, 8'hdb};
   wire [19:0] trims = {trimCoreABank0, trimCoreABank1, trimCoreBBank0, trimCoreBBank1};
   int errors = 0, samples_checked = 0;
   always #10 sys_clk = ~sys_clk;
   gain_trim_and_fir_config_regs dut (.*);
   // =====
   // Tasks
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWrStb <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      regRdStb <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1 `CHK(regRdData, e)
   endtask
   // Outputs trail a write by two edges
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic cfg(input logic [7:0] d);
      wr(12'h400, d);
      settle();
      `CHK(eqFilterEnable, d[1:0] == 2'b10)
      `CHK(coefSrcB, d[5] ? 2'b10 : {1'b0, d[6]})
      `CHK(filtersMergeOneStream, d[5])
      `CHK(sideLsbExpNeg, 6'h10 - {3'h0, d[4:2]})
      rd(12'h400, d & 8'h7f);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // =====
   // Tests
   initial begin
      #50us;
      errors++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd(12'h350 + 12'(i), 8'h00);
      rd(12'h400, 8'h00);
      `CHK(sideLsbExpNeg, 6'h10)
      $display("reset test done");
      for (int i = 0; i < 8; i++) wr(12'h350 + 12'(i), 8'he0 | 8'(i * 3 + 1));
      wr(12'h358, 8'hff);
      for (int i = 0; i < 8; i++) rd(12'h350 + 12'(i), 8'(i * 3 + 1));
      rd(12'h358, 8'h00);
      settle();
      `CHK(trims, 20'h090ea)
      @(posedge sys_clk) singleChannelMode <= 1'b1;
      settle();
      `CHK(trims, 20'h6c276)
      // Filter settings without merge are only legal in dual channel mode
      @(posedge sys_clk) singleChannelMode <= 1'b0;
      $display("trim test done");
      foreach (cfgs[i]) cfg(cfgs[i]);
      `CHK(setupWhileLinkOn, 1'b0)
      @(posedge sys_clk) serialLinkEnable <= 1'b1;
      cfg(8'h22);
      `CHK(setupWhileLinkOn, 1'b1)
      $display("config test done");
      finish_test();
   end
endmodule
